// ### core/rcseq_top.sv
// command sequencer of the reader front end
`timescale 1ns/1ps
`include "rcseq_consts.svh"
//
// Operation
// - command code written starts its execution
// - arguments and data travel through fifo
// - stream commands start at once, transceive waits kick
// - fixed argument commands wait full count
// - starting a command keeps fifo contents
// - new command code abandons running one
// - idle ends immediately
// - buffer exchange moves 25 bytes either way
// - internal buffer survives hard power-down
// - random id overwrites ten buffer bytes
// - checksum runs on until new command
// - checksum preset loaded at command start
// - self test select makes checksum run test
// - transmit sends fifo, ends when empty
// - keep code updates other bits only
// - receive ends at frame end unless multi-frame
// - transceive loops transmit then receive
// - fifo access during authentication flags error
// - authentication ends only on success
// - auth error sets protocol error, clears cipher
// - software reset restores registers, keeps buffer
module rcseq_top import rcseq_pkg::*; #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic       clk,               // 25 MHz clock
  input  wire logic       nrst,              // async reset, active low
  input  wire logic       cmd_write,         // host writes command_register
  input  wire logic [7:0] cmd_wdata,         // command_register write data
  output logic      [7:0] command_register,  // command_register readback
  output logic            receiver_off,      // receiver disabled
  output logic            soft_power_down,   // soft power-down request
  input  wire logic       host_wr_valid,     // host byte into fifo
  input  wire logic [7:0] host_wr_data,      // host fifo byte
  output logic            host_wr_ready,     // fifo accepts host byte
  output logic            host_rd_valid,     // fifo byte for host
  output logic      [7:0] host_rd_data,      // fifo byte to host
  input  wire logic       host_rd_ready,     // host takes fifo byte
  input  wire logic       transmit_kick,     // start send bit
  input  wire logic [1:0] checksum_start_value, // preset select
  input  wire logic [3:0] self_test_select,  // self test field
  input  wire logic       multi_frame_receive, // keep receiving
  input  wire logic       rx_frame_end,      // receive path frame ended
  input  wire logic       rx_byte_valid,     // received byte
  input  wire logic [7:0] rx_byte,           // received data
  input  wire logic       auth_done,         // authentication result ready
  input  wire logic       auth_ok,           // authentication succeeded
  output logic            tx_valid,          // byte to transmitter
  output logic      [7:0] tx_data,           // transmit byte
  input  wire logic       tx_ready,          // transmitter takes byte
  output logic            rx_enable,         // receive path enabled
  output logic     [15:0] checksum_result_register, // checksum result
  output logic            fifo_write_error,  // fifo access in auth or receive overflow
  output logic            protocol_error,    // authentication error
  input  wire logic       error_clear,       // host clears error flags
  output logic            cipher_active,     // cipher active status
  output logic            idle_event_flag,   // command ended pulse
  output logic            transmit_event_flag, // transmit done pulse
  output logic            receive_event_flag,  // receive done pulse
  output logic      [7:0] serial_rate_register, // serial rate code
  output logic            soft_reset_pulse   // software reset pulse
);
  // ----------------------------------------------------------------
  // synchronised pin inputs
  // ----------------------------------------------------------------
  logic [1:0] kick_s, fend_s;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      kick_s <= 2'b00;
      fend_s <= 2'b00;
    end else begin
      kick_s <= {kick_s[0], transmit_kick};
      fend_s <= {fend_s[0], rx_frame_end};
    end
  end

  // ----------------------------------------------------------------
  // fifo
  // ----------------------------------------------------------------
  rcseq_stream_if #(.W(8)) fin ();
  rcseq_stream_if #(.W(8)) fout ();
  rcseq_state_e st_q, st_d;
  logic         seq_push;
  logic   [7:0] seq_push_data;
  logic         seq_pop;
  logic         auth_busy;

  assign auth_busy  = st_q == RCSEQ_AUTH_RUN;
  // host owns the fifo unless the sequencer feeds or drains it; blocked in auth
  assign fin.valid  = seq_push || (host_wr_valid && !auth_busy);
  assign fin.data   = seq_push ? seq_push_data : host_wr_data;
  assign host_wr_ready = fin.ready && !seq_push && !auth_busy;
  assign host_rd_valid = fout.valid && !seq_pop && !auth_busy;
  assign host_rd_data  = fout.data;
  assign fout.ready = seq_pop || (host_rd_ready && !auth_busy);

  rcseq_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk   (clk),
    .nrst  (nrst),
    .flush (1'b0),
    .wr    (fin),
    .rd    (fout)
  );

  // ----------------------------------------------------------------
  // command state machine
  // ----------------------------------------------------------------
  logic [7:0]  cmd_q, cmd_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [15:0] crc_q, crc_d;
  logic [15:0] lfsr_q, lfsr_d;
  logic [7:0]  rate_q, rate_d;
  logic        perr_q, perr_d, werr_q, werr_d, ciph_q, ciph_d;
  logic        idle_ev_d, tx_ev_d, rx_ev_d, srst_d;
  logic        idle_ev_q, tx_ev_q, rx_ev_q, srst_q;
  logic [7:0]  abuf_q [`RCSEQ_AUTH_BYTES];
  logic [7:0]  ibuf_q [`RCSEQ_BUF_BYTES];
  logic        ibuf_we;
  logic [4:0]  ibuf_idx;
  logic [7:0]  ibuf_wd;
  logic        abuf_we;
  logic [3:0]  code;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ b[i]) ? ((r << 1) ^ `RCSEQ_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_byte

  function automatic logic [15:0] preset(input logic [1:0] s);
    case (s)
      2'b00:   return `RCSEQ_PRESET0;
      2'b01:   return `RCSEQ_PRESET1;
      2'b10:   return `RCSEQ_PRESET2;
      default: return `RCSEQ_PRESET3;
    endcase
  endfunction : preset

  assign code = cmd_wdata[3:0];

  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    cnt_d = cnt_q;
    crc_d = crc_q;
    lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    rate_d = rate_q;
    perr_d = perr_q && !error_clear;
    werr_d = werr_q && !error_clear;
    ciph_d = ciph_q;
    idle_ev_d = 1'b0;
    tx_ev_d = 1'b0;
    rx_ev_d = 1'b0;
    srst_d = 1'b0;
    seq_push = 1'b0;
    seq_push_data = 8'h00;
    seq_pop = 1'b0;
    ibuf_we = 1'b0;
    ibuf_idx = cnt_q;
    ibuf_wd = fout.data;
    abuf_we = 1'b0;
    tx_valid = 1'b0;
    // per-state work
    case (st_q)
      RCSEQ_IDLE: ;
      RCSEQ_MEM_IN: begin
        seq_pop = fout.valid;
        ibuf_we = fout.valid;
        if (fout.valid) cnt_d = cnt_q + 5'd1;
        if (fout.valid && cnt_q == `RCSEQ_BUF_BYTES - 5'd1) begin
          st_d = RCSEQ_IDLE;
          idle_ev_d = 1'b1;
        end
      end
      RCSEQ_MEM_OUT: begin
        seq_push = 1'b1;
        seq_push_data = ibuf_q[cnt_q];
        if (fin.ready) begin
          cnt_d = cnt_q + 5'd1;
          if (cnt_q == `RCSEQ_BUF_BYTES - 5'd1) begin
            st_d = RCSEQ_IDLE;
            idle_ev_d = 1'b1;
          end
        end
      end
      RCSEQ_RAND: begin
        ibuf_we = 1'b1;
        ibuf_wd = lfsr_q[7:0];
        cnt_d = cnt_q + 5'd1;
        if (cnt_q == `RCSEQ_RAND_BYTES - 5'd1) begin
          st_d = RCSEQ_IDLE;
          idle_ev_d = 1'b1;
        end
      end
      RCSEQ_CRC: begin
        seq_pop = fout.valid;
        if (fout.valid) crc_d = crc_byte(crc_q, fout.data);
      end
      RCSEQ_TEST: begin
        seq_push = 1'b1;
        seq_push_data = crc_q[7:0] ^ {3'b000, cnt_q};
        if (fin.ready) begin
          crc_d = crc_byte(crc_q, {3'b000, cnt_q});
          cnt_d = cnt_q + 5'd1;
          if (cnt_q == `RCSEQ_SELF_TEST_SELECT_LEN - 5'd1) begin
            st_d = RCSEQ_IDLE;
            idle_ev_d = 1'b1;
          end
        end
      end
      RCSEQ_TX: begin
        tx_valid = fout.valid;
        seq_pop = fout.valid && tx_ready;
        if (!fout.valid) begin
          tx_ev_d = 1'b1;
          if (cmd_q[3:0] == `RCSEQ_CMD_TRANSCV) begin
            st_d = RCSEQ_RX;
          end else begin
            st_d = RCSEQ_IDLE;
            idle_ev_d = 1'b1;
          end
        end
      end
      RCSEQ_RX: begin
        seq_push = rx_byte_valid;
        seq_push_data = rx_byte;
        if (rx_byte_valid && !fin.ready) werr_d = 1'b1;
        if (fend_s[1] && !multi_frame_receive) begin
          rx_ev_d = 1'b1;
          if (cmd_q[3:0] == `RCSEQ_CMD_TRANSCV) begin
            st_d = RCSEQ_TR_WAIT;
          end else begin
            st_d = RCSEQ_IDLE;
            idle_ev_d = 1'b1;
          end
        end
      end
      RCSEQ_TR_WAIT: begin
        if (kick_s[1]) st_d = RCSEQ_TX;
      end
      RCSEQ_AUTH_GET: begin
        seq_pop = fout.valid;
        abuf_we = fout.valid;
        if (fout.valid) cnt_d = cnt_q + 5'd1;
        if (fout.valid && cnt_q == 5'(`RCSEQ_AUTH_BYTES) - 5'd1) st_d = RCSEQ_AUTH_RUN;
      end
      RCSEQ_AUTH_RUN: begin
        if (host_wr_valid || host_rd_ready) werr_d = 1'b1;
        if (abuf_q[0] != `RCSEQ_AUTH_A && abuf_q[0] != `RCSEQ_AUTH_B) begin
          perr_d = 1'b1;
          ciph_d = 1'b0;
        end else if (auth_done && auth_ok) begin
          ciph_d = 1'b1;
          st_d = RCSEQ_IDLE;
          idle_ev_d = 1'b1;
        end else if (auth_done) begin
          perr_d = 1'b1;
          ciph_d = 1'b0;
        end
      end
      default: st_d = RCSEQ_IDLE;
    endcase
    // host command write with any code but keep overrides whatever runs
    if (cmd_write) begin
      cmd_d[7:4] = cmd_wdata[7:4];
      if (code != `RCSEQ_CMD_KEEP) begin
        cmd_d[3:0] = code;
        cnt_d = 5'd0;
        case (code)
          `RCSEQ_CMD_IDLE: begin
            st_d = RCSEQ_IDLE;
            idle_ev_d = 1'b1;
          end
          `RCSEQ_CMD_MEM:      st_d = fout.valid ? RCSEQ_MEM_IN : RCSEQ_MEM_OUT;
          `RCSEQ_CMD_RANDOM:   st_d = RCSEQ_RAND;
          `RCSEQ_CMD_CRC: begin
            crc_d = preset(checksum_start_value);
            st_d = (self_test_select == `RCSEQ_SELF_TEST_SELECT_ON) ? RCSEQ_TEST : RCSEQ_CRC;
          end
          `RCSEQ_CMD_TRANSMIT: st_d = RCSEQ_TX;
          `RCSEQ_CMD_RECEIVE:  st_d = RCSEQ_RX;
          `RCSEQ_CMD_TRANSCV:  st_d = RCSEQ_TR_WAIT;
          `RCSEQ_CMD_AUTH:     st_d = RCSEQ_AUTH_GET;
          `RCSEQ_CMD_SOFTRST: begin
            st_d = RCSEQ_IDLE;
            cmd_d = {4'h0, `RCSEQ_CMD_IDLE};
            crc_d = 16'h0000;
            rate_d = `RCSEQ_RATE_RESET;
            perr_d = 1'b0;
            werr_d = 1'b0;
            ciph_d = 1'b0;
            srst_d = 1'b1;
            idle_ev_d = 1'b1;
          end
          default: begin
            st_d = RCSEQ_IDLE;
            cmd_d[3:0] = `RCSEQ_CMD_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= RCSEQ_IDLE;
      cmd_q <= 8'h00;
      cnt_q <= 5'h00;
      crc_q <= 16'h0000;
      lfsr_q <= `RCSEQ_LFSR_SEED;
      rate_q <= `RCSEQ_RATE_RESET;
      perr_q <= 1'b0;
      werr_q <= 1'b0;
      ciph_q <= 1'b0;
      idle_ev_q <= 1'b0;
      tx_ev_q <= 1'b0;
      rx_ev_q <= 1'b0;
      srst_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      cnt_q <= cnt_d;
      crc_q <= crc_d;
      lfsr_q <= lfsr_d;
      rate_q <= rate_d;
      perr_q <= perr_d;
      werr_q <= werr_d;
      ciph_q <= ciph_d;
      idle_ev_q <= idle_ev_d;
      tx_ev_q <= tx_ev_d && !auth_busy;
      rx_ev_q <= rx_ev_d && !auth_busy;
      srst_q <= srst_d;
    end
  end

  // ----------------------------------------------------------------
  // buffers without reset: contents survive resets
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ibuf_we) ibuf_q[ibuf_idx] <= ibuf_wd;
    if (abuf_we) abuf_q[cnt_q[3:0]] <= fout.data;
  end

  assign command_register = cmd_q;
  assign receiver_off = cmd_q[5];
  assign soft_power_down = cmd_q[4];
  assign tx_data = fout.data;
  assign rx_enable = st_q == RCSEQ_RX;
  assign checksum_result_register = crc_q;
  assign fifo_write_error = werr_q;
  assign protocol_error = perr_q;
  assign cipher_active = ciph_q;
  assign idle_event_flag = idle_ev_q;
  assign transmit_event_flag = tx_ev_q;
  assign receive_event_flag = rx_ev_q;
  assign serial_rate_register = rate_q;
  assign soft_reset_pulse = srst_q;
endmodule : rcseq_top

// ### core/rcseq_consts.svh
// constants of the reader command sequencer
`ifndef RCSEQ_CONSTS_SVH
`define RCSEQ_CONSTS_SVH
`define RCSEQ_CMD_IDLE      4'h0
`define RCSEQ_CMD_MEM       4'h1
`define RCSEQ_CMD_RANDOM    4'h2
`define RCSEQ_CMD_CRC       4'h3
`define RCSEQ_CMD_TRANSMIT  4'h4
`define RCSEQ_CMD_KEEP      4'h7
`define RCSEQ_CMD_RECEIVE   4'h8
`define RCSEQ_CMD_TRANSCV   4'hc
`define RCSEQ_CMD_AUTH      4'he
`define RCSEQ_CMD_SOFTRST   4'hf
`define RCSEQ_BUF_BYTES     5'h19
`define RCSEQ_RAND_BYTES    5'h0a
`define RCSEQ_AUTH_BYTES    4'hc
`define RCSEQ_AUTH_A        8'h60
`define RCSEQ_AUTH_B        8'h61
`define RCSEQ_SELF_TEST_SELECT_ON   4'h9
`define RCSEQ_SELF_TEST_SELECT_LEN  5'h08
`define RCSEQ_PRESET0       16'h0000
`define RCSEQ_PRESET1       16'h6363
`define RCSEQ_PRESET2       16'ha671
`define RCSEQ_PRESET3       16'hffff
`define RCSEQ_CRC_POLY      16'h1021
`define RCSEQ_RATE_RESET    8'heb
`define RCSEQ_LFSR_SEED     16'hace1
`endif

// ### core/rcseq_pkg.sv
// types of the reader command sequencer
package rcseq_pkg;
  typedef enum logic [3:0] {
    RCSEQ_IDLE, RCSEQ_MEM_IN, RCSEQ_MEM_OUT, RCSEQ_RAND, RCSEQ_CRC, RCSEQ_TEST,
    RCSEQ_TX, RCSEQ_RX, RCSEQ_TR_WAIT, RCSEQ_AUTH_GET, RCSEQ_AUTH_RUN
  } rcseq_state_e;
endpackage : rcseq_pkg

// ### core/rcseq_stream_if.sv
// valid/ready byte stream between the sequencer and its fifo
`timescale 1ns/1ps
interface rcseq_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : rcseq_stream_if

// ### core/rcseq_fifo.sv
// parameterised fifo with registered read data
`timescale 1ns/1ps
module rcseq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic clk,   // clock
  input  wire logic nrst,  // async reset
  input  wire logic flush, // empty the fifo
  rcseq_stream_if.snk wr,  // fill side
  rcseq_stream_if.src rd   // drain side
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
  logic [WIDTH-1:0] dout_q, dout_d;
  logic             dv_q, dv_d;
  logic             full, empty, push, pop, load;

  assign full  = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  assign empty = wp_q == rp_q;
  assign wr.ready = !full && !flush;
  assign push  = wr.valid && wr.ready;
  assign rd.valid = dv_q;
  assign rd.data  = dout_q;
  // output register refilled whenever empty or consumed
  assign load  = !empty && (!dv_q || rd.ready) && !flush;
  assign pop   = load;

  always_comb begin
    wp_d   = wp_q;
    rp_d   = rp_q;
    dout_d = dout_q;
    dv_d   = dv_q;
    if (flush) begin
      wp_d = '0;
      rp_d = '0;
      dv_d = 1'b0;
    end else begin
      if (push) wp_d = wp_q + 1'b1;
      if (pop) begin
        rp_d   = rp_q + 1'b1;
        dout_d = mem_q[rp_q[AW-1:0]];
        dv_d   = 1'b1;
      end else if (rd.ready) begin
        dv_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_q   <= '0;
      rp_q   <= '0;
      dout_q <= '0;
      dv_q   <= 1'b0;
    end else begin
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      dout_q <= dout_d;
      dv_q   <= dv_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem_q[wp_q[AW-1:0]] <= wr.data;
  end
endmodule : rcseq_fifo

// ### dv/rcseq_checker.sv
// port assertions of the command sequencer
`timescale 1ns/1ps
module rcseq_checker (
  input wire logic       clk,              // clock
  input wire logic       nrst,             // reset
  input wire logic       cmd_write,        // command write
  input wire logic [7:0] cmd_wdata,        // command data
  input wire logic [7:0] command_register, // readback
  input wire logic       receiver_off,     // rx off bit
  input wire logic       rx_enable,        // rx path on
  input wire logic       cipher_active,    // cipher on
  input wire logic       idle_event_flag,  // idle pulse
  input wire logic       transmit_event_flag, // tx pulse
  input wire logic       receive_event_flag,  // rx pulse
  input wire logic [7:0] serial_rate_register, // rate
  input wire logic       soft_reset_pulse  // reset pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [3:0] code;
  assign code = cmd_wdata[3:0];
  sequence s_idle_soon;
    ##[1:2] idle_event_flag;
  endsequence
  sequence s_auth_end;
    $rose(cipher_active);
  endsequence
  AST_IDLE_WRITE: assert property (cmd_write && code == 4'h0 |-> s_idle_soon)
    else $error("idle write gave no idle pulse");
  AST_FLAG_ONE: assert property (idle_event_flag |=> !idle_event_flag)
    else $error("idle pulse longer than one cycle");
  AST_KEEP_CODE: assert property (cmd_write && code == 4'h7 |=>
    command_register[3:0] == $past(command_register[3:0]))
    else $error("keep code changed the command");
  AST_BITS: assert property (cmd_write && code != 4'hf |=>
    receiver_off == $past(cmd_wdata[5]))
    else $error("receiver off bit not taken");
  AST_CODE_TAKEN: assert property (cmd_write && code inside {4'h1, 4'h3, 4'h4,
    4'h8, 4'hc, 4'he} |=> command_register[3:0] == $past(code))
    else $error("command code not taken");
  AST_RX_ON: assert property (cmd_write && code == 4'h8 |=> rx_enable)
    else $error("receive did not enable rx path");
  AST_AUTH_QUIET: assert property (command_register[3:0] == 4'he |->
    !transmit_event_flag && !receive_event_flag)
    else $error("event flag during authentication");
  AST_AUTH_END: assert property (s_auth_end |-> ##[0:2] idle_event_flag)
    else $error("authentication success did not end");
  AST_RATE: assert property (soft_reset_pulse |-> ##[0:2] serial_rate_register == 8'heb)
    else $error("rate not restored by soft reset");
  AST_TX_EVENT: assert property (transmit_event_flag && command_register[3:0] == 4'h4 |->
    idle_event_flag)
    else $error("transmit end gave no idle pulse");
  AST_RX_EVENT: assert property (receive_event_flag && command_register[3:0] == 4'h8 |->
    idle_event_flag)
    else $error("receive end gave no idle pulse");
endmodule : rcseq_checker
bind rcseq_top rcseq_checker u_chk (.clk(clk), .nrst(nrst), .cmd_write(cmd_write),
  .cmd_wdata(cmd_wdata), .command_register(command_register), .receiver_off(receiver_off),
  .rx_enable(rx_enable), .cipher_active(cipher_active), .idle_event_flag(idle_event_flag),
  .transmit_event_flag(transmit_event_flag), .receive_event_flag(receive_event_flag),
  .serial_rate_register(serial_rate_register), .soft_reset_pulse(soft_reset_pulse));

// ### dv/rcseq_tx_sink.sv
// transmitter model taking bytes with stalls
`timescale 1ns/1ps
module rcseq_tx_sink (
  input  wire logic       clk,      // clock
  input  wire logic       nrst,     // reset
  input  wire logic       tx_valid, // byte offered
  input  wire logic [7:0] tx_data,  // byte
  output logic            tx_ready  // byte taken
);
  logic [7:0] got[$];
  logic [1:0] cnt_q;
  // stall one cycle in four
  assign tx_ready = (cnt_q != 2'h3);
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      if (tx_valid && tx_ready) got.push_back(tx_data);
    end
  end
endmodule : rcseq_tx_sink

// ### dv/rcseq_tb_top.sv
// testbench of the command sequencer
`timescale 1ns/1ps
module rcseq_tb_top;
  logic clk, nrst, cmd_write, host_wr_valid, host_rd_ready, transmit_kick;
  logic multi_frame_receive, rx_frame_end, rx_byte_valid, auth_done, auth_ok;
  logic error_clear, tx_valid, tx_ready, host_wr_ready, host_rd_valid;
  logic receiver_off, soft_power_down, rx_enable, fifo_write_error;
  logic protocol_error, cipher_active, idle_event_flag, transmit_event_flag;
  logic receive_event_flag, soft_reset_pulse;
  logic [7:0] cmd_wdata, command_register, host_wr_data, host_rd_data, rx_byte;
  logic [7:0] tx_data, serial_rate_register;
  logic [1:0] checksum_start_value;
  logic [3:0] self_test_select;
  logic [15:0] checksum_result_register;
  logic [15:0] pre[4] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
  int miscompares, n_checks;
  rcseq_top #(.FIFO_DEPTH(8)) dut (.*);
  rcseq_tx_sink u_sink (.clk(clk), .nrst(nrst), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  // ----------------
  // shared tasks
  // ----------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic cmd(input logic [7:0] w);
    cmd_write = 1'b1;
    cmd_wdata = w;
    tick(1);
    cmd_write = 1'b0;
  endtask : cmd
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (idle_event_flag !== 1'b1 && n < 300);
    #1;
    chk("idle flag", n < 300, 1);
  endtask : wait_idle
  task automatic push(input logic [7:0] b, input int c);
    int n;
    n = 0;
    host_wr_valid = 1'b1;
    for (int i = 0; i < c; i++) begin
      host_wr_data = b + i[7:0];
      do begin
        @(posedge clk);
        n++;
      end while (host_wr_ready !== 1'b1 && n < 500);
      #1;
    end
    host_wr_valid = 1'b0;
    chk("push", n < 500, 1);
  endtask : push
  task automatic pop(input logic [7:0] b, input int c);
    int n;
    n = 0;
    host_rd_ready = 1'b1;
    for (int i = 0; i < c; i++) begin
      do begin
        @(posedge clk);
        n++;
      end while (host_rd_valid !== 1'b1 && n < 500);
      chk("fifo out", host_rd_data, b + i[7:0]);
      #1;
    end
    host_rd_ready = 1'b0;
  endtask : pop
  // ----------------
  // scenarios
  // ----------------
  task automatic t_self_end();
    cmd(8'h00);
    wait_idle();
    cmd(8'h02);
    wait_idle();
    cmd(8'h05);
    tick(2);
    chk("undefined", command_register, 8'h00);
  endtask : t_self_end
  task automatic t_mem();
    push(8'h40, 8);
    chk("preload", host_rd_valid, 1);
    cmd(8'h01);
    push(8'h48, 17);
    wait_idle();
    cmd(8'h0f);
    tick(3);
    chk("rate", serial_rate_register, 16'h00eb);
    // hard power-down with the sequencer idle after the soft reset: internal buffer must survive
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    cmd(8'h01);
    // idle pulse arrives while the host still drains the fifo
    fork
      pop(8'h40, 25);
      wait_idle();
    join
  endtask : t_mem
  task automatic t_tx();
    push(8'ha0, 3);
    cmd(8'h04);
    wait_idle();
    chk("tx count", 16'(u_sink.got.size()), 3);
    for (int i = 0; i < 3; i++) chk("tx byte", u_sink.got[i], 8'ha0 + i[7:0]);
  endtask : t_tx
  task automatic t_trx();
    int n0;
    n0 = u_sink.got.size();
    push(8'hb0, 2);
    cmd(8'h0c);
    tick(6);
    chk("tr wait", 16'(u_sink.got.size() - n0), 0);
    transmit_kick = 1'b1;
    tick(3);
    transmit_kick = 1'b0;
    tick(12);
    chk("tr sent", 16'(u_sink.got.size() - n0), 2);
    chk("tr rx", rx_enable, 1);
    cmd(8'h00);
  endtask : t_trx
  task automatic t_rx();
    cmd(8'h08);
    tick(2);
    chk("rx on", rx_enable, 1);
    rx_frame_end = 1'b1;
    tick(2);
    rx_frame_end = 1'b0;
    wait_idle();
    chk("rx off", rx_enable, 0);
    multi_frame_receive = 1'b1;
    cmd(8'h08);
    rx_frame_end = 1'b1;
    tick(4);
    rx_frame_end = 1'b0;
    tick(10);
    chk("multi", rx_enable, 1);
    cmd(8'h37);
    tick(1);
    chk("keep", command_register, 8'h38);
    chk("rcv off", receiver_off, 1);
    chk("pdown", soft_power_down, 1);
    cmd(8'h00);
    tick(2);
    chk("abandon", rx_enable, 0);
    multi_frame_receive = 1'b0;
  endtask : t_rx
  task automatic t_auth(input logic [7:0] b, input logic ok);
    push(b, 8);
    cmd(8'h0e);
    push(b + 8'h08, 4);
    tick(20);
    host_wr_valid = 1'b1;
    tick(2);
    host_wr_valid = 1'b0;
    tick(2);
    chk("wr err", fifo_write_error, 1);
    auth_ok = ok;
    auth_done = 1'b1;
    tick(1);
    auth_done = 1'b0;
    tick(3);
    chk("cipher", cipher_active, ok);
    chk("proto", protocol_error, !ok);
    cmd(8'h00);
    error_clear = 1'b1;
    tick(1);
    error_clear = 1'b0;
  endtask : t_auth
  task automatic t_crc();
    for (int p = 0; p < 4; p++) begin
      checksum_start_value = p[1:0];
      cmd(8'h03);
      tick(3);
      chk("preset", checksum_result_register, pre[p]);
      cmd(8'h00);
      tick(2);
    end
    // a byte written after the fifo ran empty still enters the checksum
    checksum_start_value = 2'b00;
    cmd(8'h03);
    tick(3);
    push(8'h01, 1);
    tick(4);
    chk("crc byte", checksum_result_register, 16'h1021);
    cmd(8'h00);
    tick(2);
    self_test_select = 4'h9;
    cmd(8'h03);
    tick(40);
    chk("self test", host_rd_valid, 1);
    self_test_select = 4'h0;
  endtask : t_crc
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    {cmd_write, host_wr_valid, host_rd_ready, transmit_kick, rx_frame_end} = '0;
    {multi_frame_receive, rx_byte_valid, auth_done, auth_ok, error_clear} = '0;
    {cmd_wdata, host_wr_data, rx_byte, checksum_start_value, self_test_select} = '0;
    tick(8);
    nrst = 1'b1;
    chk("rate reset", serial_rate_register, 16'h00eb);
    t_self_end();
    t_mem();
    t_tx();
    t_trx();
    t_rx();
    t_auth(8'h60, 1'b1);
    t_auth(8'h61, 1'b0);
    t_crc();
    report_and_stop();
  end
  initial begin
    #2000000;
    miscompares++;
    report_and_stop();
  end
endmodule : rcseq_tb_top
